// ### shared/sacl_defines.svh
`ifndef SACL_DEFINES_SVH
`define SACL_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SACL_ADDR_ALTF   8'h4f
`define SACL_ADDR_CTRL   8'h5f
`define SACL_ADDR_TXL    8'h60
`define SACL_ADDR_TXH    8'h61
`define SACL_ADDR_RXL    8'h62
`define SACL_ADDR_RXH    8'h63
`define SACL_ADDR_RAW    8'hf9
`define SACL_ADDR_STAT   8'hfb
`define SACL_ADDR_MASK   8'hfd
`define SACL_ADDR_CLR    8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SACL_ALTF_LINE   0
`define SACL_CTRL_PIN    0
`define SACL_CTRL_BUSY   1
`define SACL_CTRL_DIR    2
`define SACL_CTRL_GO     3
`define SACL_CTRL_AUTO   4
`define SACL_CTRL_ERR    5
`define SACL_FLG_TO      3
`define SACL_FLG_TXC     4
`define SACL_FLG_RXC     5
`define SACL_FLG_ALL     8'h38
`define SACL_TX_BITS     14
`define SACL_RX_BITS     10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SACL_RST_BYTE    8'h00
`define SACL_RST_TXW     14'h0000
`define SACL_RST_RXW     10'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SACL_CLK_NS      4
`define SACL_TICK_NS     1000
`define SACL_TICK_CYC    (`SACL_TICK_NS / `SACL_CLK_NS)
`define SACL_BIT_US      1000
`define SACL_ONE_US      750
`define SACL_ZERO_US     250
`define SACL_THR_US      ((`SACL_ONE_US + `SACL_ZERO_US) / 2)
`define SACL_GAP_US      (2 * `SACL_BIT_US)
`define SACL_TIMEOUT_MS  100
`define SACL_TIMEOUT_US  (`SACL_TIMEOUT_MS * 1000)

`endif

// ### shared/sacl_pkg.sv
package sacl_pkg;

    typedef enum logic [3:0] {
        SACL_IDLE = 4'h1,
        SACL_TX   = 4'h2,
        SACL_WAIT = 4'h4,
        SACL_RX   = 4'h8
    } sacl_state_t;

    typedef logic [16:0] sacl_time_t;

endpackage

// ### shared/sacl_tick_if.sv
interface sacl_tick_if;
    logic usTick;
    modport gen  (output usTick);
    modport user (input  usTick);
endinterface

// ### rtl/sacl_timebase.sv
`include "sacl_defines.svh"

module sacl_timebase (
    input  logic        clock,
    input  logic        rst_b,
    sacl_tick_if.gen    tick
);
    localparam logic [7:0] LAST = 8'(`SACL_TICK_CYC - 1);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       tick_r;
    logic       tick_nxt;

    // ----------------------------------------
    // Microsecond divider
    // ----------------------------------------
    always_comb begin
        tick_nxt = (cnt_r == LAST);
        cnt_nxt  = tick_nxt ? 8'h00 : cnt_r + 8'h01;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick.usTick = tick_r;
endmodule

// ### rtl/sacl_top.sv
`include "sacl_defines.svh"

module sacl_top #(
    parameter int unsigned TIMEOUT_US = `SACL_TIMEOUT_US
) (
    input  logic       clock,
    input  logic       rst_b,
    input  logic [7:0] regAddr,
    input  logic       regWrEn,
    input  logic [7:0] regWrData,
    input  logic       regRdEn,
    output logic [7:0] regRdData,
    input  logic       antennaLineIoIn,
    output logic       antennaLineIoOut,
    output logic       antennaLineIoOe,
    input  logic       antennaLineIn,
    output logic       antennaDirectionOut,
    output logic       interruptRequestOut
);
    typedef sacl_pkg::sacl_time_t tm_t;

    localparam tm_t BIT_T  = tm_t'(`SACL_BIT_US);
    localparam tm_t ONE_T  = tm_t'(`SACL_ONE_US);
    localparam tm_t ZERO_T = tm_t'(`SACL_ZERO_US);
    localparam tm_t THR_T  = tm_t'(`SACL_THR_US);
    localparam tm_t GAP_T  = tm_t'(`SACL_GAP_US);
    localparam tm_t TO_T   = tm_t'(TIMEOUT_US);

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    sacl_tick_if tickBus ();

    sacl_timebase u_timebase (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tickBus)
    );

    logic usTick;
    assign usTick = tickBus.usTick;

    function automatic logic atEnd(input logic tk,
                                   input tm_t  t,
                                   input tm_t  lim);
        atEnd = tk && (t == lim - tm_t'(1));
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0]          altSel_r,  altSel_nxt;
    logic                pinTwo_r,  pinTwo_nxt;
    logic                dirSel_r,  dirSel_nxt;
    logic                autoRx_r,  autoRx_nxt;
    logic                receive_error_bit_r,   receive_error_bit_nxt;
    logic [13:0]         txWord_r,  txWord_nxt;
    logic [7:0]          raw_r,     raw_nxt;
    logic [7:0]          mask_r,    mask_nxt;
    logic [7:0]          rdData_r,  rdData_nxt;
    logic                irq_r,     irq_nxt;
    sacl_pkg::sacl_state_t state_r, state_nxt;
    tm_t                 timer_r,   timer_nxt;
    logic [3:0]          bitCnt_r,  bitCnt_nxt;
    logic [13:0]         txSh_r,    txSh_nxt;
    logic [9:0]          rxSh_r,    rxSh_nxt;
    logic [9:0]          rxWord_r,  rxWord_nxt;
    logic                lineOut_r, lineOut_nxt;
    logic                lineOe_r,  lineOe_nxt;
    logic                dirOut_r,  dirOut_nxt;
    logic                ioS1_r,    ioS2_r;
    logic                inS1_r,    inS2_r;
    logic                rxPrev_r;
    logic                rxLvl;
    logic                rise;
    logic                fall;
    logic                ctrlWr;
    logic                goTx;
    logic                armRx;
    logic                evTx;
    logic                evRx;
    logic                evTo;
    logic                evErr;
    logic [7:0]          evVec;
    logic [7:0]          clrVec;
    logic [7:0]          ctrlRd;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ioS1_r   <= 1'b0;
            ioS2_r   <= 1'b0;
            inS1_r   <= 1'b0;
            inS2_r   <= 1'b0;
            rxPrev_r <= 1'b0;
        end else begin
            ioS1_r   <= antennaLineIoIn;
            ioS2_r   <= ioS1_r;
            inS1_r   <= antennaLineIn;
            inS2_r   <= inS1_r;
            rxPrev_r <= rxLvl;
        end
    end

    assign rxLvl = pinTwo_r ? (inS2_r & altSel_r[`SACL_ALTF_LINE])
                            : ioS2_r;
    assign rise  = rxLvl & ~rxPrev_r;
    assign fall  = ~rxLvl & rxPrev_r;

    // ----------------------------------------
    // Start decode
    // ----------------------------------------
    assign ctrlWr = regWrEn && (regAddr == `SACL_ADDR_CTRL);
    assign goTx   = ctrlWr && regWrData[`SACL_CTRL_GO]
                    && regWrData[`SACL_CTRL_DIR]
                    && (state_r == sacl_pkg::SACL_IDLE);
    assign armRx  = ctrlWr && !regWrData[`SACL_CTRL_DIR]
                    && regWrData[`SACL_CTRL_AUTO]
                    && (state_r == sacl_pkg::SACL_IDLE);

    // ----------------------------------------
    // Link engine
    // ----------------------------------------
    always_comb begin
        state_nxt   = state_r;
        timer_nxt   = usTick ? timer_r + tm_t'(1) : timer_r;
        bitCnt_nxt  = bitCnt_r;
        txSh_nxt    = txSh_r;
        rxSh_nxt    = rxSh_r;
        rxWord_nxt  = rxWord_r;
        lineOut_nxt = 1'b0;
        lineOe_nxt  = 1'b0;
        dirOut_nxt  = 1'b0;
        evTx        = 1'b0;
        evRx        = 1'b0;
        evTo        = 1'b0;
        evErr       = 1'b0;
        case (state_r)
            sacl_pkg::SACL_IDLE: begin
                timer_nxt = tm_t'(0);
                if (goTx) begin
                    state_nxt  = sacl_pkg::SACL_TX;
                    txSh_nxt   = txWord_r;
                    bitCnt_nxt = 4'h0;
                    rxWord_nxt = `SACL_RST_RXW;
                end else if (armRx) begin
                    state_nxt  = sacl_pkg::SACL_WAIT;
                    rxWord_nxt = `SACL_RST_RXW;
                end
            end
            sacl_pkg::SACL_TX: begin
                dirOut_nxt = 1'b1;
                lineOe_nxt = 1'b1;
                lineOut_nxt = timer_r < (txSh_r[13] ? ONE_T : ZERO_T);
                if (atEnd(usTick, timer_r, BIT_T)) begin
                    timer_nxt  = tm_t'(0);
                    txSh_nxt   = {txSh_r[12:0], 1'b0};
                    bitCnt_nxt = bitCnt_r + 4'h1;
                    if (bitCnt_r == 4'(`SACL_TX_BITS - 1)) begin
                        evTx = 1'b1;
                        lineOe_nxt = 1'b0;
                        dirOut_nxt = 1'b0;
                        state_nxt  = autoRx_r ? sacl_pkg::SACL_WAIT
                                              : sacl_pkg::SACL_IDLE;
                    end
                end
            end
            sacl_pkg::SACL_WAIT: begin
                if (rise) begin
                    state_nxt  = sacl_pkg::SACL_RX;
                    timer_nxt  = tm_t'(0);
                    bitCnt_nxt = 4'h0;
                end else if (atEnd(usTick, timer_r, TO_T)) begin
                    evTo      = 1'b1;
                    state_nxt = sacl_pkg::SACL_IDLE;
                end
            end
            sacl_pkg::SACL_RX: begin
                if (rise) begin
                    timer_nxt = tm_t'(0);
                end else if (fall) begin
                    rxSh_nxt   = {rxSh_r[8:0], (timer_r >= THR_T)};
                    bitCnt_nxt = bitCnt_r + 4'h1;
                    if (bitCnt_r == 4'(`SACL_RX_BITS - 1)) begin
                        evRx       = 1'b1;
                        rxWord_nxt = {rxSh_r[8:0], (timer_r >= THR_T)};
                        state_nxt  = sacl_pkg::SACL_IDLE;
                    end
                end else if (atEnd(usTick, timer_r, GAP_T)) begin
                    evTo      = 1'b1;
                    evErr     = 1'b1;
                    state_nxt = sacl_pkg::SACL_IDLE;
                end
            end
            default: begin
                state_nxt = sacl_pkg::SACL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= sacl_pkg::SACL_IDLE;
            timer_r   <= tm_t'(0);
            bitCnt_r  <= 4'h0;
            txSh_r    <= `SACL_RST_TXW;
            rxSh_r    <= `SACL_RST_RXW;
            rxWord_r  <= `SACL_RST_RXW;
            lineOut_r <= 1'b0;
            lineOe_r  <= 1'b0;
            dirOut_r  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            timer_r   <= timer_nxt;
            bitCnt_r  <= bitCnt_nxt;
            txSh_r    <= txSh_nxt;
            rxSh_r    <= rxSh_nxt;
            rxWord_r  <= rxWord_nxt;
            lineOut_r <= lineOut_nxt;
            lineOe_r  <= lineOe_nxt;
            dirOut_r  <= dirOut_nxt;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    assign evVec  = {2'b00, evRx, evTx, evTo, 3'b000};
    assign clrVec = (regWrEn && regAddr == `SACL_ADDR_CLR)
                    ? regWrData : `SACL_RST_BYTE;
    assign ctrlRd = {2'b00, receive_error_bit_r, autoRx_r, 1'b0, dirSel_r,
                     (state_r != sacl_pkg::SACL_IDLE), pinTwo_r};

    always_comb begin
        altSel_nxt = altSel_r;
        pinTwo_nxt = pinTwo_r;
        dirSel_nxt = dirSel_r;
        autoRx_nxt = autoRx_r;
        txWord_nxt = txWord_r;
        mask_nxt   = mask_r;
        rdData_nxt = rdData_r;
        if (regWrEn) begin
            case (regAddr)
                `SACL_ADDR_ALTF: begin
                    altSel_nxt = regWrData;
                end
                `SACL_ADDR_CTRL: begin
                    pinTwo_nxt = regWrData[`SACL_CTRL_PIN];
                    dirSel_nxt = regWrData[`SACL_CTRL_DIR];
                    autoRx_nxt = regWrData[`SACL_CTRL_AUTO];
                end
                `SACL_ADDR_TXL: begin
                    txWord_nxt[7:0] = regWrData;
                end
                `SACL_ADDR_TXH: begin
                    txWord_nxt[13:8] = regWrData[5:0];
                end
                `SACL_ADDR_MASK: begin
                    mask_nxt = regWrData & `SACL_FLG_ALL;
                end
                default: begin
                end
            endcase
        end
        raw_nxt   = ((raw_r & ~clrVec) | evVec) & `SACL_FLG_ALL;
        receive_error_bit_nxt = evErr | (receive_error_bit_r & ~(goTx | armRx));
        irq_nxt   = |(raw_nxt & mask_nxt);
        if (regRdEn) begin
            case (regAddr)
                `SACL_ADDR_ALTF: rdData_nxt = altSel_r;
                `SACL_ADDR_CTRL: rdData_nxt = ctrlRd;
                `SACL_ADDR_TXL:  rdData_nxt = txWord_r[7:0];
                `SACL_ADDR_TXH:  rdData_nxt = {2'b00, txWord_r[13:8]};
                `SACL_ADDR_RXL:  rdData_nxt = rxWord_r[7:0];
                `SACL_ADDR_RXH:  rdData_nxt = {6'h00, rxWord_r[9:8]};
                `SACL_ADDR_RAW:  rdData_nxt = raw_r;
                `SACL_ADDR_STAT: rdData_nxt = raw_r & mask_r;
                `SACL_ADDR_MASK: rdData_nxt = mask_r;
                default:         rdData_nxt = `SACL_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            altSel_r <= `SACL_RST_BYTE;
            pinTwo_r <= 1'b0;
            dirSel_r <= 1'b0;
            autoRx_r <= 1'b0;
            receive_error_bit_r  <= 1'b0;
            txWord_r <= `SACL_RST_TXW;
            raw_r    <= `SACL_RST_BYTE;
            mask_r   <= `SACL_RST_BYTE;
            rdData_r <= `SACL_RST_BYTE;
            irq_r    <= 1'b0;
        end else begin
            altSel_r <= altSel_nxt;
            pinTwo_r <= pinTwo_nxt;
            dirSel_r <= dirSel_nxt;
            autoRx_r <= autoRx_nxt;
            receive_error_bit_r  <= receive_error_bit_nxt;
            txWord_r <= txWord_nxt;
            raw_r    <= raw_nxt;
            mask_r   <= mask_nxt;
            rdData_r <= rdData_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign regRdData           = rdData_r;
    assign antennaLineIoOut    = lineOut_r;
    assign antennaLineIoOe     = lineOe_r;
    assign antennaDirectionOut = dirOut_r;
    assign interruptRequestOut = irq_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_tx_launch: assert property (
        goTx |=> ##[1:2] (antennaLineIoOe && antennaLineIoOut))
        else $error("transmit did not start driving line");

    chk_dir_drive: assert property (
        antennaLineIoOe |-> antennaDirectionOut)
        else $error("direction low while driving line");

    chk_line_release: assert property (
        evTx |=> !antennaLineIoOe && !antennaDirectionOut)
        else $error("line not released after word");

    chk_wiring_sel: assert property (
        ctrlWr |=> pinTwo_r == $past(regWrData[`SACL_CTRL_PIN]))
        else $error("wiring bit not taken");

    chk_txc_flag: assert property (
        evTx |=> raw_r[`SACL_FLG_TXC])
        else $error("transmit-complete flag missing");

    chk_rxc_flag: assert property (
        evRx |=> raw_r[`SACL_FLG_RXC] && state_r == sacl_pkg::SACL_IDLE)
        else $error("receive-complete flag missing");

    chk_timeout_flag: assert property (
        evTo |=> raw_r[`SACL_FLG_TO])
        else $error("timeout flag missing");

    chk_rx_error: assert property (
        evErr |=> receive_error_bit_r && raw_r[`SACL_FLG_TO])
        else $error("receive error not reported");

    chk_irq_gate: assert property (
        ##1 (interruptRequestOut == |(raw_r & mask_r)))
        else $error("interrupt does not follow masked flags");

    chk_wait_edge: assert property (
        (state_r == sacl_pkg::SACL_WAIT && rise)
        |=> state_r == sacl_pkg::SACL_RX && timer_r == tm_t'(0))
        else $error("reply edge did not stop wait");
endmodule

// ### bench/sacl_antenna_model.sv
module sacl_antenna_model (
    input  logic clock,
    input  logic rst_b,
    input  logic lineLevel,
    input  logic replyStart,
    output logic replyDrive,
    output logic replyOe,
    output int   highCycles
);
    timeunit 1ns;
    timeprecision 100ps;
    int replyCyc;
    // ----------------------------------------
    // Antenna with short zero-valued reply
    // ----------------------------------------
    // Ten pulses on request
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) replyCyc <= 0;
        else if (replyStart) replyCyc <= 1;
        else if (replyCyc != 0 && replyCyc < 168)
            replyCyc <= replyCyc + 1;
        else replyCyc <= 0;
    end
    assign replyOe    = (replyCyc != 0);
    assign replyDrive = replyOe && (replyCyc <= 160)
                        && (((replyCyc - 1) % 16) < 8);
    // Length of current high pulse on line
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) highCycles <= 0;
        else if (lineLevel) highCycles <= highCycles + 1;
        else highCycles <= 0;
    end
endmodule

// ### bench/smart_antenna_control_link_test.sv
`include "sacl_defines.svh"
module smart_antenna_control_link_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TO_US = 50;
    localparam int LIMIT = 40000;
    logic       clock;
    logic       rst_b;
    logic [7:0] regAddr;
    logic       regWrEn;
    logic [7:0] regWrData;
    logic       regRdEn;
    logic [7:0] regRdData;
    logic       lineOut;
    logic       lineOe;
    logic       lineLevel;
    logic       dirOut;
    logic       irqOut;
    logic       replyDrive;
    logic       replyOe;
    logic       replyStart;
    int         highCycles;
    int         fails;
    int         total_checks;
    int         cycles;
    logic [7:0] rdVal;
    logic [7:0] offs [11];
    // ----------------------------------------
    // Design and antenna
    // ----------------------------------------
    assign lineLevel = lineOe ? lineOut : (replyOe ? replyDrive : 1'b0);
    sacl_top #(.TIMEOUT_US(TO_US)) sacl_top_i (
        .clock(clock), .rst_b(rst_b), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .antennaLineIoIn(lineLevel),
        .antennaLineIoOut(lineOut), .antennaLineIoOe(lineOe),
        .antennaLineIn(lineLevel), .antennaDirectionOut(dirOut),
        .interruptRequestOut(irqOut));
    sacl_antenna_model sacl_antenna_model_i (
        .clock(clock), .rst_b(rst_b), .lineLevel(lineLevel),
        .replyStart(replyStart),
        .replyDrive(replyDrive), .replyOe(replyOe),
        .highCycles(highCycles));
    // ----------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(string what, logic exp, logic got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        #1 regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clock);
        #1 regWrEn = 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clock);
        #1 regAddr = a;
        regRdEn = 1'b1;
        @(posedge clock);
        #1 regRdEn = 1'b0;
        @(posedge clock);
        #1 rdVal = regRdData;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_vals();
        offs = '{8'h4f, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'hf9,
                 8'hfb, 8'hfd, 8'hff, 8'h10};
        for (int i = 0; i < 11; i++) begin
            rd(offs[i]);
            chk8("reset value", 8'h00, rdVal);
        end
        chk1("irq after reset", 1'b0, irqOut);
    endtask
    task automatic t_rw();
        wr(`SACL_ADDR_ALTF, 8'ha5);
        wr(`SACL_ADDR_TXL, 8'h5a);
        wr(`SACL_ADDR_TXH, 8'hea);
        wr(`SACL_ADDR_MASK, 8'h38);
        wr(`SACL_ADDR_CTRL, 8'h01);
        wr(8'h10, 8'hff);
        rd(`SACL_ADDR_ALTF);
        chk8("alt select", 8'ha5, rdVal);
        rd(`SACL_ADDR_TXL);
        chk8("tx low", 8'h5a, rdVal);
        rd(`SACL_ADDR_TXH);
        chk8("tx high", 8'h2a, rdVal);
        rd(`SACL_ADDR_MASK);
        chk8("mask", 8'h38, rdVal);
        rd(`SACL_ADDR_CTRL);
        chk8("pin mode", 8'h01, rdVal);
        rd(8'h10);
        chk8("unmapped", 8'h00, rdVal);
        wr(`SACL_ADDR_CTRL, 8'h00);
        wr(`SACL_ADDR_MASK, 8'h00);
    endtask
    task automatic t_timeout();
        wr(`SACL_ADDR_CTRL, 8'h10);
        repeat (TO_US * 250 - 1000) @(posedge clock);
        rd(`SACL_ADDR_RAW);
        chk8("raw before limit", 8'h00, rdVal);
        chk1("dir receiving", 1'b0, dirOut);
        repeat (1700) @(posedge clock);
        rd(`SACL_ADDR_RAW);
        chk8("raw timeout", 8'h08, rdVal);
        rd(`SACL_ADDR_STAT);
        chk8("masked status", 8'h00, rdVal);
        chk1("irq masked", 1'b0, irqOut);
        rd(`SACL_ADDR_CTRL);
        chk8("no rx error", 8'h10, rdVal);
        rd(`SACL_ADDR_RXL);
        chk8("rx low empty", 8'h00, rdVal);
        wr(`SACL_ADDR_MASK, 8'h08);
        repeat (2) @(posedge clock);
        #1 chk1("irq unmasked", 1'b1, irqOut);
        rd(`SACL_ADDR_STAT);
        chk8("status timeout", 8'h08, rdVal);
        wr(`SACL_ADDR_CLR, 8'h08);
        repeat (2) @(posedge clock);
        #1 chk1("irq cleared", 1'b0, irqOut);
        rd(`SACL_ADDR_RAW);
        chk8("raw cleared", 8'h00, rdVal);
    endtask
    task automatic t_tx();
        wr(`SACL_ADDR_TXL, 8'h00);
        wr(`SACL_ADDR_TXH, 8'h20);
        wr(`SACL_ADDR_CTRL, 8'h1c);
        @(posedge clock);
        #1 chk1("line enable", 1'b1, lineOe);
        chk1("dir sending", 1'b1, dirOut);
        chk1("first pulse", 1'b1, lineOut);
        rd(`SACL_ADDR_CTRL);
        chk8("busy", 8'h16, rdVal);
        repeat (1000) @(posedge clock);
        chk1("pulse held", 1'b1, highCycles > 1000);
        rd(`SACL_ADDR_RAW);
        chk8("no raw yet", 8'h00, rdVal);
        #1 rst_b = 1'b0;
        #1 chk1("abort enable", 1'b0, lineOe);
        chk1("abort dir", 1'b0, dirOut);
        repeat (16) @(posedge clock);
        #1 rst_b = 1'b1;
        rd(`SACL_ADDR_RAW);
        chk8("raw after reset", 8'h00, rdVal);
    endtask
    task automatic t_rx(logic two);
        wr(`SACL_ADDR_ALTF, 8'h01);
        wr(`SACL_ADDR_CTRL, {7'h08, two});
        chk1("dir listening", 1'b0, dirOut);
        @(posedge clock);
        #1 replyStart = 1'b1;
        @(posedge clock);
        #1 replyStart = 1'b0;
        repeat (200) @(posedge clock);
        rd(`SACL_ADDR_RAW);
        chk8("raw rx complete", 8'h20, rdVal);
        chk1("irq rx masked", 1'b0, irqOut);
        rd(`SACL_ADDR_CTRL);
        chk8("rx ctrl no error", {7'h08, two}, rdVal);
        rd(`SACL_ADDR_RXL);
        chk8("rx low zero", 8'h00, rdVal);
        rd(`SACL_ADDR_RXH);
        chk8("rx high zero", 8'h00, rdVal);
        wr(`SACL_ADDR_CLR, 8'h20);
        wr(`SACL_ADDR_CTRL, 8'h00);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        fails = 0;
        total_checks = 0;
        cycles = 0;
        rst_b = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        replyStart = 1'b0;
        repeat (16) @(posedge clock);
        #1 rst_b = 1'b1;
        t_reset_vals();
        t_rw();
        t_timeout();
        t_rx(1'b0);
        t_rx(1'b1);
        t_tx();
        summarize();
    end
endmodule
